/* pattern_pkg.sv */
// Shared types, constants and helpers for the pattern exposure link
package pattern_pkg;
    localparam int PIX_W = 24;
    localparam int IDX_W = 5;
    localparam int TIME_W = 32;
    localparam int PAT_W = 8;
    localparam int ILL_W = 3;
    localparam logic [IDX_W-1:0] MAX_PAT_8BIT = 5'h03;
    localparam logic [IDX_W-1:0] MAX_PAT_1BIT = 5'h18;
    localparam logic [IDX_W-1:0] MAX_PAT_INT = 5'h1f;
    localparam longint CLK_HZ = 200_000_000;
    localparam longint CLK_PERIOD_NS = 5;
    localparam longint FRAME_TRIG_MIN_US = 20;
    localparam int FRAME_TRIG_CYC = int'((FRAME_TRIG_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Frame rate limits in milli-hertz
    localparam longint RATE_8BIT_MHZ = 120_000;
    localparam longint RATE_1BIT_MHZ = 104_200;
    localparam int PERIOD_8BIT_CYC = int'((CLK_HZ * 1000 + RATE_8BIT_MHZ - 1) / RATE_8BIT_MHZ);
    localparam int PERIOD_1BIT_CYC = int'((CLK_HZ * 1000 + RATE_1BIT_MHZ - 1) / RATE_1BIT_MHZ);
    localparam longint VSYNC_LOSS_MS = 200;
    localparam int VSYNC_LOSS_CYC = int'(VSYNC_LOSS_MS * CLK_HZ / 1000);
    localparam int PCLK_HALF_CYC = 16;
    localparam int VSYNC_PCLKS = 4;
    localparam int ACTIVE_PCLKS = 16;
    localparam logic [1:0] RST_SYNC_INIT = 2'h3;

    typedef enum logic [1:0] {MODE_EXT8 = 2'h0, MODE_EXT1 = 2'h1, MODE_INT = 2'h2} mode_t;
    typedef enum logic [4:0] {S_IDLE = 5'h01, S_PRE = 5'h02, S_EXP = 5'h04, S_POST = 5'h08, S_FILL = 5'h10}
        seq_state_t;
    typedef enum logic [2:0] {L_IDLE = 3'h1, L_SYNC = 3'h2, L_ACT = 3'h4} src_state_t;

    // Number of patterns per group, clamped to what the mode can carry
    function automatic logic [IDX_W-1:0] eff_count(input mode_t m, input logic [IDX_W-1:0] n);
        logic [IDX_W-1:0] lim;
        lim = (m == MODE_EXT8) ? MAX_PAT_8BIT : (m == MODE_EXT1) ? MAX_PAT_1BIT : MAX_PAT_INT;
        if (n == 5'h00)
            eff_count = 5'h01;
        else if (n > lim)
            eff_count = lim;
        else
            eff_count = n;
    endfunction

    // Next index in a group, wrapping to zero
    function automatic logic [IDX_W-1:0] next_idx(input mode_t m, input logic [IDX_W-1:0] i,
                                                  input logic [IDX_W-1:0] n);
        next_idx = (i + 5'h01 >= eff_count(m, n)) ? 5'h00 : i + 5'h01;
    endfunction
endpackage

/* pattern_link_if.sv */
// Parallel pixel link between the pattern source and the sequencer
`timescale 1ns/1ps
interface pattern_link_if;
    logic        pclk;       // Pixel clock, made by the source
    logic        vsync;      // Frame sync, active high
    logic        de;         // Pixel data valid
    logic [23:0] pixel_bus;  // 24-bit pixel word

    modport source (output pclk, output vsync, output de, output pixel_bus);
    modport display (input pclk, input vsync, input de, input pixel_bus);
endinterface

/* delayed_pulse.sv */
// Delayed fixed-width trigger pulse generator
`timescale 1ns/1ps
module delayed_pulse
    import pattern_pkg::*;
(
    input  wire logic              clk,     // System clock
    input  wire logic              sys_rst, // Synchronous reset
    input  wire logic              fire,    // Start request pulse
    input  wire logic [TIME_W-1:0] delay,   // Cycles from fire to pulse
    output logic                   pulse_r  // Active-high pulse
);
    logic              wait_r;
    logic [TIME_W-1:0] cnt_r;

    // A fire during the pulse is dropped so the width never shrinks
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wait_r  <= 1'b0;
            pulse_r <= 1'b0;
            cnt_r   <= '0;
        end
        else if (fire && !pulse_r)
        begin
            wait_r <= 1'b1;
            cnt_r  <= '0;
        end
        else if (wait_r)
        begin
            if (cnt_r >= delay)
            begin
                wait_r  <= 1'b0;
                pulse_r <= 1'b1;
                cnt_r   <= '0;
            end
            else
                cnt_r <= cnt_r + 32'h1;
        end
        else if (pulse_r)
        begin
            if (cnt_r >= TIME_W'(FRAME_TRIG_CYC - 1))
                pulse_r <= 1'b0;
            else
                cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule

/* pattern_exposure_sequencer.sv */
// Pattern exposure sequencer: display end of the parallel pattern link
`timescale 1ns/1ps
module pattern_exposure_sequencer
    import pattern_pkg::*;
#(
    parameter int LOSS_CYC = VSYNC_LOSS_CYC                // Cycles without a frame before halting
)
(
    input  wire logic                  clk,                   // System clock, 200 MHz
    input  wire logic                  sys_rst,               // Synchronous reset, active high
    pattern_link_if.display            link,                  // Parallel pixel link
    input  wire pattern_pkg::mode_t    mode,                  // Pattern mode
    input  wire logic [IDX_W-1:0]      pat_count,             // Patterns per frame or group
    input  wire logic [3*ILL_W-1:0]    illum_per_pat,         // 8-bit mode illuminator per pattern
    input  wire logic [ILL_W-1:0]      illum_all,             // Illuminator for 1-bit and internal
    input  wire logic [TIME_W-1:0]     dark_before_time,      // Dark cycles before exposure
    input  wire logic [TIME_W-1:0]     exposure_time,         // Exposure cycles
    input  wire logic [TIME_W-1:0]     dark_after_time,       // Dark cycles after exposure
    input  wire logic [TIME_W-1:0]     frame_trigger_delay,   // Frame trigger delay cycles
    input  wire logic [TIME_W-1:0]     pattern_trigger_delay, // Pattern trigger delay cycles
    input  wire logic                  frame_trig_high,       // Frame trigger active high
    input  wire logic                  pat_trig_high,         // Pattern trigger active high
    input  wire logic                  start_internal,        // Host command: start stored patterns
    input  wire logic                  pattern_advance_in,    // Advance pin, asynchronous
    input  wire logic [PAT_W-1:0]      stored_pattern,        // Stored pattern at pattern_index
    output logic                       frame_trigger_out,     // Frame trigger pin
    output logic                       pattern_trigger_out,   // Pattern trigger pin
    output logic [ILL_W-1:0]           illum_on,              // Illuminator enables
    output logic [PAT_W-1:0]           mirror_data,           // Pattern to mirrors
    output logic                       mirror_show,           // Pattern shown this cycle
    output logic [IDX_W-1:0]           pattern_index,         // Current pattern number
    output logic                       halted                 // Frame sync lost
);
    import pattern_pkg::*;

    // ------------------------------------------------------------
    // Link domain: capture one word per frame
    // ------------------------------------------------------------
    logic [1:0]       lrst_r;
    logic             lreq_r;
    logic [1:0]       lack_s_r;
    logic             vs_d_r;
    logic             armed_r;
    logic             tog_r;
    logic [PIX_W-1:0] word_l_r;

    always_ff @(posedge link.pclk)
    begin
        lrst_r <= {lrst_r[0], lreq_r};
    end

    // Link reset stays requested until the pixel clock side has taken it
    always_ff @(posedge clk)
    begin
        lack_s_r <= {lack_s_r[0], lrst_r[1]};
        if (sys_rst)
            lreq_r <= 1'b1;
        else if (lack_s_r[1])
            lreq_r <= 1'b0;
    end

    always_ff @(posedge link.pclk)
    begin
        vs_d_r <= link.vsync;
        if (lrst_r[1])
        begin
            armed_r <= 1'b0;
            tog_r   <= 1'b0;
        end
        else if (link.vsync && !vs_d_r)
            armed_r <= 1'b1;
        else if (armed_r && link.de)
        begin
            armed_r  <= 1'b0;
            word_l_r <= link.pixel_bus;
            tog_r    <= ~tog_r;
        end
    end

    // ------------------------------------------------------------
    // Crossings into the system clock
    // ------------------------------------------------------------
    logic [2:0]       tog_s_r;
    logic [2:0]       adv_s_r;
    logic [PIX_W-1:0] frame_word_r;
    logic             frame_evt;
    logic             adv_evt;

    always_ff @(posedge clk)
    begin
        if (sys_rst || lreq_r || lack_s_r[1])
        begin
            tog_s_r <= 3'h0;
            adv_s_r <= 3'h0;
        end
        else
        begin
            tog_s_r <= {tog_s_r[1:0], tog_r};
            adv_s_r <= {adv_s_r[1:0], pattern_advance_in};
        end
    end

    assign frame_evt = tog_s_r[2] ^ tog_s_r[1];
    assign adv_evt   = adv_s_r[1] & ~adv_s_r[2];

    // Word has been stable since before the toggle arrived
    always_ff @(posedge clk)
    begin
        if (frame_evt)
            frame_word_r <= word_l_r;
    end

    // ------------------------------------------------------------
    // Frame sync watchdog
    // ------------------------------------------------------------
    logic [TIME_W-1:0] loss_cnt_r;
    logic              loss_evt;

    assign loss_evt = (mode != MODE_INT) && !frame_evt && (loss_cnt_r == TIME_W'(LOSS_CYC - 1));

    always_ff @(posedge clk)
    begin
        if (sys_rst || frame_evt || mode == MODE_INT)
        begin
            loss_cnt_r <= '0;
            halted     <= 1'b0;
        end
        else if (loss_evt)
            halted <= 1'b1;
        else if (!halted)
            loss_cnt_r <= loss_cnt_r + 32'h1;
    end

    // ------------------------------------------------------------
    // Start decisions
    // ------------------------------------------------------------
    logic             run_int_r;
    logic [IDX_W-1:0] grp_r;
    logic             ext;
    logic             start_evt;

    assign ext       = (mode != MODE_INT);
    assign start_evt = ext ? frame_evt : (run_int_r && adv_evt);

    always_ff @(posedge clk)
    begin
        if (sys_rst || ext)
        begin
            run_int_r <= 1'b0;
            grp_r     <= '0;
        end
        else if (start_internal)
        begin
            run_int_r <= 1'b1;
            grp_r     <= '0;
        end
        else if (start_evt)
            grp_r <= next_idx(mode, grp_r, pat_count);
    end

    // ------------------------------------------------------------
    // Exposure sequencer
    // ------------------------------------------------------------
    seq_state_t        state_r;
    logic [TIME_W-1:0] cnt_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst || loss_evt)
        begin
            state_r       <= S_IDLE;
            cnt_r         <= '0;
            pattern_index <= '0;
        end
        else if (start_evt)
        begin
            state_r       <= S_PRE;
            cnt_r         <= '0;
            pattern_index <= ext ? 5'h00 : grp_r;
        end
        else
        begin
            unique case (state_r)
                S_IDLE: cnt_r <= '0;
                S_PRE:
                    if (cnt_r + 32'h1 >= dark_before_time)
                    begin
                        state_r <= S_EXP;
                        cnt_r   <= '0;
                    end
                    else
                        cnt_r <= cnt_r + 32'h1;
                S_EXP:
                    if (cnt_r + 32'h1 >= exposure_time)
                    begin
                        state_r <= S_POST;
                        cnt_r   <= '0;
                    end
                    else
                        cnt_r <= cnt_r + 32'h1;
                S_POST:
                    if (cnt_r + 32'h1 >= dark_after_time)
                    begin
                        cnt_r <= '0;
                        if (ext && next_idx(mode, pattern_index, pat_count) != 5'h00)
                        begin
                            state_r       <= S_PRE;
                            pattern_index <= pattern_index + 5'h01;
                        end
                        else
                            state_r <= S_FILL;
                    end
                    else
                        cnt_r <= cnt_r + 32'h1;
                S_FILL: cnt_r <= '0;
                default:
                begin
                    state_r <= S_IDLE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mirror data and illumination
    // ------------------------------------------------------------
    logic [PAT_W-1:0] pat_nxt;
    logic [ILL_W-1:0] ill_nxt;

    always_comb
    begin
        unique case (mode)
            MODE_EXT8:
            begin
                pat_nxt = frame_word_r[{pattern_index[1:0], 3'h0} +: PAT_W];
                ill_nxt = illum_per_pat[4'(pattern_index[1:0]) * 4'h3 +: ILL_W];
            end
            MODE_EXT1:
            begin
                pat_nxt = {PAT_W{frame_word_r[pattern_index]}};
                ill_nxt = illum_all;
            end
            default:
            begin
                pat_nxt = stored_pattern;
                ill_nxt = illum_all;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            illum_on    <= '0;
            mirror_data <= '0;
            mirror_show <= 1'b0;
        end
        else
        begin
            illum_on    <= (state_r == S_EXP) ? ill_nxt : '0;
            mirror_data <= (state_r == S_EXP) ? pat_nxt : '0;
            mirror_show <= (state_r == S_EXP);
        end
    end

    // ------------------------------------------------------------
    // Trigger outputs
    // ------------------------------------------------------------
    logic              ft_pulse;
    logic              pt_act_r;
    logic [TIME_W-1:0] since_r;

    delayed_pulse u_frame_trig (
        .clk     (clk),
        .sys_rst (sys_rst),
        .fire    (start_evt && (ext || grp_r == 5'h00)),
        .delay   (frame_trigger_delay),
        .pulse_r (ft_pulse)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst || start_evt || state_r == S_POST)
        begin
            since_r  <= '0;
            pt_act_r <= 1'b0;
        end
        else if (state_r == S_PRE || state_r == S_EXP)
        begin
            if (since_r != 32'hffffffff)
                since_r <= since_r + 32'h1;
            if (since_r == pattern_trigger_delay)
                pt_act_r <= 1'b1;
        end
        else
            pt_act_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            frame_trigger_out   <= 1'b0;
            pattern_trigger_out <= 1'b0;
        end
        else
        begin
            frame_trigger_out   <= ft_pulse ~^ frame_trig_high;
            pattern_trigger_out <= pt_act_r ~^ pat_trig_high;
        end
    end
endmodule

/* pattern_source.sv */
// Pattern source: drives frames onto the parallel pattern link
`timescale 1ns/1ps
module pattern_source
    import pattern_pkg::*;
#(
    parameter int PER8_CYC = PERIOD_8BIT_CYC,        // Least frame period, 8-bit mode
    parameter int PER1_CYC = PERIOD_1BIT_CYC         // Least frame period, 1-bit mode
)
(
    input  wire logic             clk,          // System clock, 200 MHz
    input  wire logic             sys_rst,      // Synchronous reset, active high
    pattern_link_if.source        link,         // Parallel pixel link
    input  wire logic             one_bit_mode, // Frame pacing for 1-bit patterns
    input  wire logic             stream_en,    // Send frames continuously
    input  wire logic [PIX_W-1:0] word_in,      // Pattern word for later frames
    input  wire logic             word_load,    // Load word_in
    output logic                  frame_sent    // Pulse: a frame began
);
    import pattern_pkg::*;

    // ------------------------------------------------------------
    // Pixel clock divider
    // ------------------------------------------------------------
    logic [4:0] div_r;
    logic       pclk_r;
    logic       fall;

    assign fall = (div_r == 5'(PCLK_HALF_CYC - 1)) && pclk_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_r  <= '0;
            pclk_r <= 1'b0;
        end
        else if (div_r == 5'(PCLK_HALF_CYC - 1))
        begin
            div_r  <= '0;
            pclk_r <= ~pclk_r;
        end
        else
            div_r <= div_r + 5'h1;
    end

    // ------------------------------------------------------------
    // Frame pacing
    // ------------------------------------------------------------
    logic [TIME_W-1:0] per_r;
    logic [PIX_W-1:0]  hold_r;
    logic              pend_r;
    logic [TIME_W-1:0] per_lim;

    assign per_lim = one_bit_mode ? TIME_W'(PER1_CYC - 1) : TIME_W'(PER8_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            hold_r <= '0;
        else if (word_load)
            hold_r <= word_in;
    end

    // Frames repeat so the sync never stops while streaming
    always_ff @(posedge clk)
    begin
        if (sys_rst || !stream_en)
        begin
            per_r  <= '0;
            pend_r <= 1'b0;
        end
        else if (per_r >= per_lim)
        begin
            per_r  <= '0;
            pend_r <= 1'b1;
        end
        else
        begin
            per_r <= per_r + 32'h1;
            if (fall && pend_r)
                pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Link sequencer, updated on the pixel clock falling edge
    // ------------------------------------------------------------
    src_state_t st_r;
    logic [4:0] lcnt_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r           <= L_IDLE;
            lcnt_r         <= '0;
            link.vsync     <= 1'b0;
            link.de        <= 1'b0;
            link.pixel_bus <= '0;
            frame_sent     <= 1'b0;
        end
        else
        begin
            frame_sent <= 1'b0;
            if (fall)
            begin
                unique case (st_r)
                    L_IDLE:
                        if (pend_r)
                        begin
                            st_r       <= L_SYNC;
                            lcnt_r     <= '0;
                            link.vsync <= 1'b1;
                            frame_sent <= 1'b1;
                        end
                    L_SYNC:
                        if (lcnt_r == 5'(VSYNC_PCLKS - 1))
                        begin
                            st_r           <= L_ACT;
                            lcnt_r         <= '0;
                            link.vsync     <= 1'b0;
                            link.de        <= 1'b1;
                            link.pixel_bus <= hold_r;
                        end
                        else
                            lcnt_r <= lcnt_r + 5'h1;
                    L_ACT:
                        if (lcnt_r == 5'(ACTIVE_PCLKS - 1))
                        begin
                            st_r    <= L_IDLE;
                            link.de <= 1'b0;
                        end
                        else
                            lcnt_r <= lcnt_r + 5'h1;
                    default:
                    begin
                        st_r       <= L_IDLE;
                        link.vsync <= 1'b0;
                        link.de    <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        link.pclk <= pclk_r;
    end
endmodule

/* pattern_link_checker.sv */
// Assertions on the pattern link and the display outputs
`timescale 1ns/1ps
module pattern_link_checker
    import pattern_pkg::*;
(
    input wire logic             clk,                 // System clock
    input wire logic             sys_rst,             // Sync reset
    input wire logic             pclk,                // Pixel clock
    input wire logic             vsync,               // Frame sync
    input wire logic             de,                  // Data valid
    input wire logic [23:0]      pixel_bus,           // Pixel word
    input wire logic             frame_trigger_out,   // Frame trigger
    input wire logic             pattern_trigger_out, // Pattern trigger
    input wire logic [ILL_W-1:0] illum_on,            // Illuminators
    input wire logic [PAT_W-1:0] mirror_data,         // Mirror pattern
    input wire logic             mirror_show,         // Exposure
    input wire logic             halted               // Sync lost
);
    logic [15:0] ftw_r;

    // ----------------------------------------
    // Frame trigger width counter
    // ----------------------------------------
    always_ff @(posedge clk)
        ftw_r <= (sys_rst || !frame_trigger_out) ? 16'h0000 : ftw_r + 16'h0001;

    sequence de_run8;
        de [*8];
    endsequence

    chk_vsync_len: assert property (@(posedge pclk) disable iff (sys_rst)
        $rose(vsync) |-> vsync [*4] ##1 !vsync) else $error("vsync width wrong");
    chk_de_len: assert property (@(posedge pclk) disable iff (sys_rst)
        $rose(de) |-> de_run8 ##1 de_run8 ##1 !de) else $error("data valid width wrong");
    chk_word_stable: assert property (@(posedge pclk) disable iff (sys_rst)
        de && $past(de) |-> $stable(pixel_bus)) else $error("pixel word moved");
    chk_sync_no_data: assert property (@(posedge pclk) disable iff (sys_rst)
        vsync |-> !de) else $error("data valid during sync");
    chk_ftrig_width: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(frame_trigger_out) |-> ftw_r == 16'(FRAME_TRIG_CYC)) else $error("frame trigger width");
    chk_dark_off: assert property (@(posedge clk) disable iff (sys_rst)
        !mirror_show |-> illum_on == 3'h0 && mirror_data == 8'h00) else $error("light in dark time");
    chk_ptrig_exp: assert property (@(posedge clk) disable iff (sys_rst)
        mirror_show |-> pattern_trigger_out) else $error("pattern trigger off in exposure");
    chk_ptrig_end: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(mirror_show) |-> ##[1:2] !pattern_trigger_out) else $error("pattern trigger overlong");
    chk_halt_dark: assert property (@(posedge clk) disable iff (sys_rst)
        halted |-> !mirror_show && illum_on == 3'h0) else $error("light while halted");
endmodule

/* pattern_exposure_sequencer_tb.sv */
// Self-checking bench: source and sequencer joined by the pattern link
`timescale 1ns/1ps
module pattern_exposure_sequencer_tb;
    import pattern_pkg::*;
    localparam int PER = 5000;
    localparam int LOSS = 12000;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    mode_t mode = MODE_EXT8;
    logic [4:0] pat_count = 5'h03, pidx;
    logic [8:0] ipp = 9'h000;
    logic [2:0] iall = 3'h1, illum;
    logic [31:0] t_pre = 32'h10, t_exp = 32'h10, t_post = 32'h8, t_fd = 32'h4, t_pd = 32'h8;
    logic start_int = 1'b0, adv = 1'b0, stream_en = 1'b0, word_load = 1'b0, pol = 1'b1;
    logic ftrig, ptrig, show, halted, frame_sent;
    logic [7:0] stored = 8'h00, mdata;
    logic [23:0] word = 24'h000000;
    logic [31:0] seed = 32'h64b22e8c;
    int mismatches = 0, num_checks = 0, nft = 0, npt = 0, exp_ft = 0, npush = 0, run = 0;
    logic show_d = 1'b0, ft_d = 1'b0, pt_d = 1'b0;
    time s0 = 0;
    logic [15:0] exp_q[$];
    pattern_link_if link();

    pattern_source #(.PER8_CYC(PER), .PER1_CYC(PER)) i_pattern_source (.clk(clk), .sys_rst(sys_rst),
        .link(link), .one_bit_mode(mode == MODE_EXT1), .stream_en(stream_en), .word_in(word),
        .word_load(word_load), .frame_sent(frame_sent));
    pattern_exposure_sequencer #(.LOSS_CYC(LOSS)) i_pattern_exposure_sequencer (.clk(clk), .sys_rst(sys_rst),
        .link(link), .mode(mode), .pat_count(pat_count), .illum_per_pat(ipp), .illum_all(iall),
        .dark_before_time(t_pre), .exposure_time(t_exp), .dark_after_time(t_post), .frame_trigger_delay(t_fd),
        .pattern_trigger_delay(t_pd), .frame_trig_high(pol), .pat_trig_high(pol), .start_internal(start_int),
        .pattern_advance_in(adv), .stored_pattern(stored), .frame_trigger_out(ftrig), .pattern_trigger_out(ptrig),
        .illum_on(illum), .mirror_data(mdata), .mirror_show(show), .pattern_index(pidx), .halted(halted));
    pattern_link_checker i_pattern_link_checker (.clk(clk), .sys_rst(sys_rst), .pclk(link.pclk),
        .vsync(link.vsync), .de(link.de), .pixel_bus(link.pixel_bus), .frame_trigger_out(ftrig),
        .pattern_trigger_out(ptrig), .illum_on(illum), .mirror_data(mdata), .mirror_show(show), .halted(halted));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wait_frame;
        for (int i = 0; i < 2 * PER && !frame_sent; i++)
            @(posedge clk) #1;
        check("frame_sent", 1, frame_sent);
        @(posedge clk) #1;
    endtask

    // ----------------------------------------
    // Two frames of one external mode
    // ----------------------------------------
    task automatic stream(input mode_t m, input logic [4:0] n);
        seed = lfsr(seed);
        mode = m;
        pat_count = n;
        word = seed[23:0];
        ipp = seed[31:23];
        iall = seed[26:24] | 3'h1;
        t_pre = 32'd8 + seed[2:0];
        t_exp = 32'd10 + seed[6:3];
        t_post = 32'd4 + seed[9:7];
        t_pd = t_pre - 32'd4;
        t_fd = t_pre + seed[15:10];
        word_load = 1'b1;
        @(posedge clk) #1;
        word_load = 1'b0;
        stream_en = 1'b1;
        repeat (2) wait_frame;
        stream_en = 1'b0;
        repeat (PER) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------
    // Reference model of shown patterns
    // ----------------------------------------
    always @(negedge clk)
    begin
        if (frame_sent && mode != MODE_INT)
        begin
            exp_ft++;
            for (int k = 0; k < pat_count; k++)
                exp_q.push_back({k[4:0], mode == MODE_EXT8 ? ipp[3*k+:3] : iall,
                                 mode == MODE_EXT8 ? word[8*k+:8] : {8{word[k]}}});
            npush += pat_count;
        end
        if (show && !show_d)
            check("pattern", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, {pidx, illum, mdata});
        if (show)
            run++;
        else if (show_d)
        begin
            check("exposure", t_exp, run);
            run = 0;
        end
        if (show && !show_d && pidx == 5'h00)
            s0 = $time;
        if (ftrig && !ft_d && mode != MODE_INT)
            check("ftrig_delay", (t_fd + 32'd1 - t_pre) * 32'd5, 32'($time - s0));
        nft += int'(ftrig && !ft_d);
        npt += int'(ptrig && !pt_d);
        {show_d, ft_d, pt_d} = {show, ftrig, ptrig};
    end

    initial
        forever #2.5 clk = ~clk;

    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        complete_run;
    end

    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        stream(MODE_EXT8, 5'h03);
        stream(MODE_EXT1, 5'h18);
        repeat (LOSS) @(posedge clk);
        #1;
        adv = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        adv = 1'b0;
        check("halted", 1, halted);
        stream(MODE_EXT8, 5'h02);
        check("halted", 0, halted);
        mode = MODE_INT;
        pat_count = 5'h02;
        stored = seed[7:0];
        start_int = 1'b1;
        @(posedge clk) #1;
        start_int = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            exp_q.push_back({5'(k % 2), iall, stored});
            npush++;
            exp_ft += int'(k % 2 == 0);
            adv = 1'b1;
            repeat (20) @(posedge clk);
            #1;
            adv = 1'b0;
            repeat (PER) @(posedge clk);
            #1;
        end
        check("queue", 0, exp_q.size());
        check("frame_trigs", exp_ft, nft);
        check("pattern_trigs", npush, npt);
        pol = 1'b0;
        repeat (2) @(posedge clk) #1;
        check("trig_pol", 2'h3, {ftrig, ptrig});
        complete_run;
    end
endmodule
